// ### src/ebc_pkg.sv
package ebc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W  = 24;
    localparam int DATA_W  = 16;
    localparam int NUM_WIN = 4;
    localparam int CS_W    = 5;
    localparam int CNT_W   = 4;
    localparam int DIV_W   = 4;
    localparam int FC_W    = 6;
    localparam int TC_W    = 8;
    localparam int AS_W    = 16;

    ////////////////////////////////////////////////////////////////////////
    // Internal peripheral bus ranges; the gap between them goes external
    localparam logic [23:0] IPB0_LO = 24'h20_0000;
    localparam logic [23:0] IPB0_HI = 24'h20_67FF;
    localparam logic [23:0] IPB1_LO = 24'h20_8000;
    localparam logic [23:0] IPB1_HI = 24'h20_BFFF;

    ////////////////////////////////////////////////////////////////////////
    // Reset and idle values, timing
    localparam logic [4:0]  CS_IDLE    = 5'h1F;
    localparam logic [1:0]  OE_OFF     = 2'h3;
    localparam logic [DIV_W-1:0] REF_HALF_DEF = 4'h1; // Half ref period
    localparam logic [6:0]  SEG_BITS   = 7'h7F;       // A16..A22 at most

    ////////////////////////////////////////////////////////////////////////
    // Field layouts, lowest field last
    typedef struct packed {
        logic rdy_pol;
        logic rdy_en;
        logic cs_en;
        logic mux;
        logic bus16;
        logic en;
    } ebc_fcon_type;

    typedef struct packed {
        logic [1:0] hold;
        logic [3:0] dw;
        logic [1:0] aw;
    } ebc_tcon_type;

    typedef struct packed {
        logic [11:0] base;
        logic [3:0]  size;
    } ebc_asel_type;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_START = 6'h02,
        ST_ADDR  = 6'h04,
        ST_STRB  = 6'h08,
        ST_HOLD  = 6'h10,
        ST_IPB   = 6'h20
    } ebc_state_type;

endpackage

// ### src/ebc_win_if.sv
`timescale 1ns/10ps
interface ebc_win_if;
    logic [23:0]           addr;
    ebc_pkg::ebc_asel_type asel;
    logic                  en;
    logic                  hit;

    modport match (input addr, input asel, input en, output hit);
    modport ctrl  (output addr, output asel, output en, input hit);
endinterface

// ### src/ebc_win_match.sv
`timescale 1ns/10ps
// Window covers 4 KiB shifted left by the size code
module ebc_win_match (
    ebc_win_if.match w
);
    logic [11:0] mask;

    // Compare only the bits above the window size
    assign mask  = 12'hFFF << w.asel.size;
    assign w.hit = w.en && (((w.addr[23:12] ^ w.asel.base) & mask) == 12'h000);
endmodule // ebc_win_match

// ### src/ebc_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; value moves once stages two and three agree
module ebc_sync #(
    parameter int W = 1
) (
    input  wire logic         i_mclk,
    input  wire logic         i_nrst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_val
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } ebc_sync_type;

    ebc_sync_type st_q;
    ebc_sync_type st_d;

    // Stage one is only read by stage two
    always_comb begin
        st_d    = st_q;
        st_d.s1 = i_pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.val = st_q.s3;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    assign o_val = st_q.val;
endmodule // ebc_sync

// ### src/ebc_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// - Every external and internal peripheral bus access goes through here
// - Single-chip mode makes no external access; else external bus mode
// - External address width programmable from zero to 24 bits
// - Data bus width byte or halfword; transfers sized to it
// - Multiplexed or demultiplexed bus operation selectable
// - Demultiplexed mode drives low address on dedicated address lines
// - Number of segment lines selectable, 64 KiB up to 8 MiB
// - Optional chip selects, one per window plus default
// - Per-window timing and function settings set bus timing
// - Ready input extends access; software selects its active level
// - Four programmable address windows, each with own settings
// - Window four beats three, window two beats one
// - Addresses outside all windows use default settings, set zero
// - Only the selected window asserts its chip select
// - Bus phases follow the rising edge of the reference clock out
// - Bus mode switches per access to match the selected window
// - Reserved areas are issued as external accesses
module ebc_ctrl #(
    parameter logic [3:0] REF_HALF = ebc_pkg::REF_HALF_DEF
) (
    input  wire logic         i_mclk,
    input  wire logic         i_nrst,
    input  wire logic         i_ce,
    // Internal request port
    input  wire logic         i_req,
    input  wire logic [23:0]  i_addr,
    input  wire logic         i_wr,
    input  wire logic         i_word,
    input  wire logic [15:0]  i_wdata,
    output logic              o_ack,
    output logic              o_err,
    output logic [15:0]       o_rdata,
    // Configuration
    input  wire logic         i_single_chip,
    input  wire logic [4:0]   i_addr_width,
    input  wire logic [2:0]   i_seg_lines,
    input  wire logic [7:0]   i_default_timing_config,
    input  wire logic [5:0]   i_default_function_config,
    input  wire logic [3:0][7:0]  i_window_timing_config,
    input  wire logic [3:0][5:0]  i_window_function_config,
    input  wire logic [3:0][15:0] i_window_address_select,
    // Internal peripheral bus
    output logic              o_ipb_req,
    output logic [23:0]       o_ipb_addr,
    output logic              o_ipb_wr,
    output logic              o_ipb_word,
    output logic [15:0]       o_ipb_wdata,
    input  wire logic         i_ipb_ack,
    input  wire logic [15:0]  i_ipb_rdata,
    // External pins
    output logic              o_bus_reference_clock_out,
    output logic [23:0]       o_addr,
    input  wire logic [15:0]  i_ad,
    output logic [15:0]       o_ad_o,
    output logic [1:0]        o_ad_oe_n,
    output logic              o_ale,
    output logic              o_rd_n,
    output logic              o_wr_n,
    output logic              o_bhe_n,
    output logic [4:0]        o_cs_n,
    input  wire logic         i_ready
);
    typedef struct packed {
        ebc_pkg::ebc_state_type state;
        logic [3:0]             div;
        logic                   refclk;
        logic [3:0]             cnt;
        logic [2:0]             win;
        logic [23:0]            addr;
        logic                   wr;
        logic                   word;
        logic [15:0]            wdata;
        logic [15:0]            rdata;
        logic                   second;
        logic                   ack;
        logic                   err;
        ebc_pkg::ebc_fcon_type  fc;
        ebc_pkg::ebc_tcon_type  tc;
        logic                   ale;
        logic                   rd_n;
        logic                   wr_n;
        logic                   bhe_n;
        logic [4:0]             cs_n;
        logic [15:0]            ad_o;
        logic [1:0]             ad_oe_n;
        logic [23:0]            addr_o;
        logic                   ipb_req;
    } ebc_ctl_type;

    localparam ebc_ctl_type RST = '{
        state: ebc_pkg::ST_IDLE, cs_n: ebc_pkg::CS_IDLE,
        ad_oe_n: ebc_pkg::OE_OFF, rd_n: 1'h1, wr_n: 1'h1, bhe_n: 1'h1,
        default: '0};

    ebc_ctl_type           st_q;
    ebc_ctl_type           st_d;
    logic [3:0]            hit;
    logic [2:0]            sel_win;
    ebc_pkg::ebc_fcon_type sel_fc;
    ebc_pkg::ebc_tcon_type sel_tc;
    logic                  ipb_hit;
    logic                  tick;
    logic                  go_addr;
    logic                  rdy_s;
    logic                  rdy_act;
    logic [15:0]           din;
    logic [24:0]           wmask;
    logic [7:0]            smask;
    logic [23:0]           amask;
    logic [15:0]           lane_wd;
    logic [15:0]           lane_rd;

    ////////////////////////////////////////////////////////////////////////
    // Window decode, one matcher per window
    ebc_win_if wif[4] ();

    for (genvar g = 0; g < 4; g++) begin : g_win
        assign wif[g].addr = i_addr;
        assign wif[g].asel = ebc_pkg::ebc_asel_type'(i_window_address_select[g]);
        assign wif[g].en   = i_window_function_config[g][0];
        assign hit[g]      = wif[g].hit;
        ebc_win_match u_match (.w(wif[g]));
    end

    // Later windows override earlier ones; no hit keeps set zero
    always_comb begin
        sel_win = 3'h0;
        sel_fc  = ebc_pkg::ebc_fcon_type'(i_default_function_config);
        sel_tc  = ebc_pkg::ebc_tcon_type'(i_default_timing_config);
        for (int i = 0; i < 4; i++) begin
            if (hit[i]) begin
                sel_win = 3'(i + 1);
                sel_fc  = ebc_pkg::ebc_fcon_type'(i_window_function_config[i]);
                sel_tc  = ebc_pkg::ebc_tcon_type'(i_window_timing_config[i]);
            end
        end
    end

    // Reserved gap is not listed, so it falls through to the pins
    assign ipb_hit = ((i_addr >= ebc_pkg::IPB0_LO) && (i_addr <= ebc_pkg::IPB0_HI))
                  || ((i_addr >= ebc_pkg::IPB1_LO) && (i_addr <= ebc_pkg::IPB1_HI));

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs and address masks
    ebc_sync #(.W(1))  u_rdy_sync (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_ce   (i_ce),
        .i_pin  (i_ready),
        .o_val  (rdy_s)
    );
    ebc_sync #(.W(16)) u_ad_sync (
        .i_mclk (i_mclk),
        .i_nrst (i_nrst),
        .i_ce   (i_ce),
        .i_pin  (i_ad),
        .o_val  (din)
    );

    assign rdy_act = (rdy_s == st_q.fc.rdy_pol);
    assign wmask   = (25'h1 << i_addr_width) - 25'h1;
    assign smask   = (8'h01 << i_seg_lines) - 8'h01;
    assign amask   = wmask[23:0] & {1'h0, smask[6:0], 16'hFFFF};

    // Byte lanes: a byte rides both lanes on a wide bus, lane 0 on a narrow
    always_comb begin
        if (st_q.fc.bus16) begin
            lane_wd = st_q.word ? st_q.wdata : {2{st_q.wdata[7:0]}};
            lane_rd = st_q.word ? din
                    : (st_q.addr[0] ? {8'h00, din[15:8]} : {8'h00, din[7:0]});
        end else begin
            lane_wd = st_q.second ? {8'h00, st_q.wdata[15:8]}
                                  : {8'h00, st_q.wdata[7:0]};
            lane_rd = st_q.second ? {din[7:0], st_q.rdata[7:0]}
                                  : {8'h00, din[7:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer; every phase boundary is a rising reference clock edge
    always_comb begin
        st_d     = st_q;
        st_d.ack = 1'h0;
        st_d.err = 1'h0;
        tick     = 1'h0;
        go_addr  = 1'h0;
        if (st_q.div == REF_HALF - 4'h1) begin
            st_d.div    = 4'h0;
            st_d.refclk = ~st_q.refclk;
            tick        = ~st_q.refclk;
        end else begin
            st_d.div = st_q.div + 4'h1;
        end
        case (st_q.state)
            ebc_pkg::ST_IDLE: begin
                if (i_req && !st_q.ack) begin
                    st_d.addr   = i_addr;
                    st_d.wr     = i_wr;
                    st_d.word   = i_word;
                    st_d.wdata  = i_wdata;
                    st_d.rdata  = 16'h0000;
                    st_d.second = 1'h0;
                    st_d.win    = sel_win;
                    st_d.fc     = sel_fc;
                    st_d.tc     = sel_tc;
                    if (ipb_hit) begin
                        st_d.state   = ebc_pkg::ST_IPB;
                        st_d.ipb_req = 1'h1;
                    end else if (i_single_chip) begin
                        st_d.ack = 1'h1;
                        st_d.err = 1'h1;
                    end else begin
                        st_d.state = ebc_pkg::ST_START;
                    end
                end
            end
            ebc_pkg::ST_START: begin
                go_addr = tick;
            end
            ebc_pkg::ST_ADDR: begin
                if (tick && st_q.cnt != 4'h0) begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end else if (tick) begin
                    st_d.state   = ebc_pkg::ST_STRB;
                    st_d.ale     = 1'h0;
                    st_d.cnt     = st_q.tc.dw;
                    st_d.rd_n    = st_q.wr;
                    st_d.wr_n    = ~st_q.wr;
                    st_d.ad_o    = lane_wd;
                    st_d.ad_oe_n = st_q.wr ? {~st_q.fc.bus16, 1'h0}
                                           : ebc_pkg::OE_OFF;
                end
            end
            ebc_pkg::ST_STRB: begin
                if (tick && st_q.cnt != 4'h0) begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end else if (tick && (!st_q.fc.rdy_en || rdy_act)) begin
                    st_d.state = ebc_pkg::ST_HOLD;
                    st_d.rd_n  = 1'h1;
                    st_d.wr_n  = 1'h1;
                    st_d.cnt   = {2'h0, st_q.tc.hold};
                    if (!st_q.wr) begin
                        st_d.rdata = lane_rd;
                    end
                end
            end
            ebc_pkg::ST_HOLD: begin
                if (tick && st_q.cnt != 4'h0) begin
                    st_d.cnt = st_q.cnt - 4'h1;
                end else if (tick) begin
                    st_d.ad_oe_n = ebc_pkg::OE_OFF;
                    // Narrow bus splits a halfword into two byte cycles
                    if (!st_q.fc.bus16 && st_q.word && !st_q.second) begin
                        st_d.second = 1'h1;
                        st_d.addr   = st_q.addr + 24'h00_0001;
                        go_addr     = 1'h1;
                    end else begin
                        st_d.state = ebc_pkg::ST_IDLE;
                        st_d.cs_n  = ebc_pkg::CS_IDLE;
                        // Idle lines stay legal when width config changes
                        st_d.addr_o = 24'h00_0000;
                        st_d.ack   = 1'h1;
                    end
                end
            end
            ebc_pkg::ST_IPB: begin
                if (i_ipb_ack) begin
                    st_d.state   = ebc_pkg::ST_IDLE;
                    st_d.ipb_req = 1'h0;
                    st_d.rdata   = i_ipb_rdata;
                    st_d.ack     = 1'h1;
                end
            end
            default: begin
                st_d = RST;
            end
        endcase
        // Address phase set-up, shared by first and second byte cycle
        if (go_addr) begin
            st_d.state = ebc_pkg::ST_ADDR;
            st_d.ale   = 1'h1;
            st_d.cnt   = {2'h0, st_q.tc.aw};
            st_d.cs_n  = st_q.fc.cs_en ? ~(5'h01 << st_q.win)
                                       : ebc_pkg::CS_IDLE;
            st_d.bhe_n = ~(st_q.fc.bus16 && (st_q.word || st_d.addr[0]));
            if (st_q.fc.mux) begin
                st_d.addr_o  = {st_d.addr[23:16] & amask[23:16], 16'h0000};
                st_d.ad_o    = st_d.addr[15:0] & amask[15:0];
                st_d.ad_oe_n = 2'h0;
            end else begin
                st_d.addr_o  = st_d.addr & amask;
                st_d.ad_oe_n = ebc_pkg::OE_OFF;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= RST;
        end else if (i_ce) begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign o_ack                     = st_q.ack;
    assign o_err                     = st_q.err;
    assign o_rdata                   = st_q.rdata;
    assign o_ipb_req                 = st_q.ipb_req;
    assign o_ipb_addr                = st_q.addr;
    assign o_ipb_wr                  = st_q.wr;
    assign o_ipb_word                = st_q.word;
    assign o_ipb_wdata               = st_q.wdata;
    assign o_bus_reference_clock_out = st_q.refclk;
    assign o_addr                    = st_q.addr_o;
    assign o_ad_o                    = st_q.ad_o;
    assign o_ad_oe_n                 = st_q.ad_oe_n;
    assign o_ale                     = st_q.ale;
    assign o_rd_n                    = st_q.rd_n;
    assign o_wr_n                    = st_q.wr_n;
    assign o_bhe_n                   = st_q.bhe_n;
    assign o_cs_n                    = st_q.cs_n;

    ////////////////////////////////////////////////////////////////////////
    // Checks; frozen cycles are skipped since state does not move
    logic take;
    assign take = (st_q.state == ebc_pkg::ST_IDLE) && i_req && !st_q.ack;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst || !i_ce);

    a_ipb_route: assert property (
        (take && ipb_hit) |=> o_ipb_req && !o_ale && (o_cs_n == 5'h1F))
        else $error("peripheral access not routed inward");
    a_single_chip: assert property (
        (take && !ipb_hit && i_single_chip) |=> o_ack && o_err ##1 !o_ack)
        else $error("single-chip access not refused");
    a_addr_width: assert property (
        (o_addr & ~wmask[23:0]) == 24'h00_0000)
        else $error("address bit above programmed width");
    a_bhe_narrow: assert property (
        (o_ale && !st_q.fc.bus16) |-> o_bhe_n && (o_ad_oe_n[1] || st_q.fc.mux))
        else $error("high byte used on narrow bus");
    a_ale_mux: assert property (
        (o_ale && st_q.fc.mux) |-> (o_ad_oe_n == 2'h0)
            && (o_ad_o == (st_q.addr[15:0] & amask[15:0])))
        else $error("multiplexed address phase wrong");
    a_demux_addr: assert property (
        (o_ale && !st_q.fc.mux) |-> (o_ad_oe_n == 2'h3)
            && (o_addr[15:0] == (st_q.addr[15:0] & amask[15:0])))
        else $error("demultiplexed address lines wrong");
    a_seg_lines: assert property (
        !o_addr[23] && ((o_addr[22:16] & ~smask[6:0]) == 7'h00))
        else $error("inactive segment line driven");
    a_ready_wait: assert property (
        (st_q.state == ebc_pkg::ST_STRB && st_q.cnt == 4'h0 && tick
            && st_q.fc.rdy_en && !rdy_act)
        |=> (st_q.state == ebc_pkg::ST_STRB) && !(o_rd_n && o_wr_n))
        else $error("strobe ended without ready");
    a_win_high: assert property (
        (take && hit[3]) |=> (st_q.win == 3'h4))
        else $error("window four did not win");
    a_win_pair: assert property (
        (take && hit[2] && !hit[3] && hit[1]) |=> (st_q.win == 3'h3))
        else $error("higher window lost an overlap");
    a_default_set: assert property (
        (take && (hit == 4'h0)) |=> (st_q.win == 3'h0))
        else $error("default set not chosen");
    a_cs_only: assert property (
        (o_cs_n == 5'h1F) || (~o_cs_n == (5'h01 << st_q.win)))
        else $error("unselected chip select active");
    a_ref_edge: assert property (
        $rose(o_ale) |-> $rose(o_bus_reference_clock_out))
        else $error("address phase off the reference edge");

    c_ext_write: cover property (o_ack && st_q.wr && !o_err && !st_q.fc.mux);
    c_ext_read_mux: cover property (o_ack && !st_q.wr && st_q.fc.mux);
    c_ready_wait: cover property (st_q.state == ebc_pkg::ST_STRB
        && st_q.fc.rdy_en && !rdy_act && tick && st_q.cnt == 4'h0);
    c_two_bytes: cover property (o_ack && st_q.second);
endmodule // ebc_ctrl

// ### bench/ebc_ext_mem.sv
`timescale 1ns/10ps
// External byte memory on the parallel bus, with a slow ready line
module ebc_ext_mem (
    input  wire logic        i_mclk,
    input  wire logic        i_mux,
    input  wire logic        i_narrow,
    input  wire logic        i_pol,
    input  wire logic [23:0] i_addr,
    input  wire logic [15:0] i_ad_o,
    input  wire logic        i_ale,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_bhe_n,
    output logic      [15:0] o_ad,
    output logic             o_ready
);
    logic [7:0]  mem [logic [23:0]];
    logic [23:0] a;
    logic        wr_q = 1'b0;
    int          strb = 0;

    // Unwritten cells answer a pattern built from the address
    function automatic logic [7:0] rd(input logic [23:0] x);
        return mem.exists(x) ? mem[x] : x[7:0] ^ 8'h5a;
    endfunction

    initial o_ad = 16'h0000;

    // Latch address in the address phase, store at write strobe end
    always @(posedge i_mclk) begin
        if (i_ale)
            a = {i_addr[23:16], i_mux ? i_ad_o : i_addr[15:0]};
        if (wr_q && i_wr_n) begin
            if (!a[0] || i_narrow)
                mem[a] = i_ad_o[7:0];
            if (!i_narrow && !i_bhe_n)
                mem[{a[23:1], 1'b1}] = i_ad_o[15:8];
        end
        wr_q = !i_wr_n;
        strb = (i_rd_n && i_wr_n) ? 0 : strb + 1;
        // Ready comes late so a ready access is stretched unless a freeze comes before ready rises
        o_ready <= (strb > 3) ? i_pol : !i_pol;
        // Data driven early so it is settled well before strobe end
        if (i_ale || !i_rd_n)
            o_ad <= i_narrow ? {~rd(a), rd(a)}
                             : {rd({a[23:1], 1'b1}), rd({a[23:1], 1'b0})};
        else
            o_ad <= ~o_ad; // Released lines toggle, so old data never stays steady
    end
endmodule // ebc_ext_mem

// ### bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam logic [4:0]  MUX_T = 5'h06;
    localparam logic [4:0]  NAR_T = 5'h0C;
    localparam logic [23:0] BASE [5] = '{24'h05_0000, 24'h10_8000,
        24'h10_0000, 24'h30_8000, 24'h30_0000};
    logic             i_mclk = 0, i_nrst = 0, i_req = 0, i_wr = 0;
    logic             i_word = 0, i_ipb_ack = 0, i_single_chip = 0;
    logic [23:0]      i_addr = 0, a_seen, ipb_seen, a;
    logic [15:0]      i_wdata = 0, i_ipb_rdata = 0, q, d, i_ad, o_rdata;
    logic [4:0]       i_addr_width = 5'h18, cs_seen = 5'h1F, o_cs_n;
    logic [2:0]       i_seg_lines = 3'h7;
    logic [3:0][5:0]  fcw = {6'h1B, 6'h09, 6'h0D, 6'h0F};
    logic [3:0][15:0] asel = {16'h3000, 16'h3004, 16'h1000, 16'h1004};
    logic [23:0]      o_addr, o_ipb_addr;
    logic [15:0]      o_ad_o, o_ipb_wdata;
    logic [1:0]       o_ad_oe_n;
    logic             o_ack, o_err, o_ale, o_rd_n, o_wr_n, o_bhe_n, e, wd;
    logic             o_ipb_req, i_ready, mux = 0, nar = 0, pol = 0;
    logic             i_ce = 1, ale_q = 0, rk = 1, rck, o_ipb_wr, o_ipb_word;
    logic [17:0]      ipw;
    logic [7:0]       em [logic [23:0]];
    int               bad_count = 0, checked = 0, cyc = 0, r;
    int               aw_t [4] = '{24, 16, 24, 20};
    int               sl_t [4] = '{7, 7, 2, 0};

    ebc_ctrl DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_req(i_req), .i_addr(i_addr), .i_wr(i_wr), .i_word(i_word),
        .i_wdata(i_wdata), .o_ack(o_ack), .o_err(o_err), .o_rdata(o_rdata),
        .i_single_chip(i_single_chip), .i_addr_width(i_addr_width),
        .i_seg_lines(i_seg_lines), .i_default_timing_config(8'h0C),
        .i_default_function_config(6'h0A), .i_window_timing_config(
        {4{8'h0C}}), .i_window_function_config(fcw),
        .i_window_address_select(asel), .o_ipb_req(o_ipb_req),
        .o_ipb_addr(o_ipb_addr), .o_ipb_wr(o_ipb_wr),
        .o_ipb_word(o_ipb_word),
        .o_ipb_wdata(o_ipb_wdata), .i_ipb_ack(i_ipb_ack),
        .i_ipb_rdata(i_ipb_rdata), .o_bus_reference_clock_out(rck),
        .o_addr(o_addr), .i_ad(i_ad), .o_ad_o(o_ad_o),
        .o_ad_oe_n(o_ad_oe_n), .o_ale(o_ale), .o_rd_n(o_rd_n),
        .o_wr_n(o_wr_n), .o_bhe_n(o_bhe_n), .o_cs_n(o_cs_n),
        .i_ready(i_ready));

    ebc_ext_mem mem (.i_mclk(i_mclk), .i_mux(mux), .i_narrow(nar),
        .i_pol(pol), .i_addr(o_addr), .i_ad_o(o_ad_o), .i_ale(o_ale),
        .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_bhe_n(o_bhe_n), .o_ad(i_ad),
        .o_ready(i_ready));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] mb(input logic [23:0] x);
        return em.exists(x) ? em[x] : x[7:0] ^ 8'h5a;
    endfunction

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One request held until its acknowledge, entered at a falling edge
    task automatic acc(input logic [23:0] ad, input logic w, input logic h,
                       input logic [15:0] wdat);
        // A frozen acknowledge of the last access must not end this one
        while (o_ack !== 1'b0) @(negedge i_mclk);
        cs_seen = 5'h1F;
        i_addr <= ad;
        i_wr <= w;
        i_word <= h;
        i_wdata <= wdat;
        i_req <= 1'b1;
        do @(negedge i_mclk); while (o_ack !== 1'b1);
        q = o_rdata;
        e = o_err;
        i_req <= 1'b0;
        @(negedge i_mclk);
    endtask

    task automatic results();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial forever #10 i_mclk = ~i_mclk;

    // Pin watch plus hang guard; a hang counts as a mismatch
    always @(posedge i_mclk) begin
        cs_seen <= cs_seen & o_cs_n;
        if (o_ale === 1'b1)
            a_seen <= o_addr;
        // Address phase must open on a rising reference clock edge
        if (o_ale === 1'b1 && !ale_q)
            rk <= rk & rck;
        ale_q <= o_ale;
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            results();
        end
    end

    // Peripheral bus responder with random acknowledge delay
    always @(negedge i_mclk) begin
        i_ipb_ack <= o_ipb_req === 1'b1 && !i_ipb_ack && $urandom % 2 != 0;
        i_ipb_rdata <= o_ipb_addr[15:0] ^ 16'h3c3c;
        i_ce <= $urandom % 8 != 0; // Random freezes of all design state
        if (o_ipb_req === 1'b1) begin
            ipb_seen <= o_ipb_addr;
            ipw <= {o_ipb_wr, o_ipb_word, o_ipb_wdata};
        end
    end

    initial begin
        void'($urandom(46874));
        repeat (6) @(negedge i_mclk);
        i_nrst <= 1'b1;
        @(negedge i_mclk);
        // Random write and read back over the default set and all windows
        for (int i = 0; i < 40; i++) begin
            r = $urandom % 5;
            wd = 1'($urandom);
            d = 16'($urandom);
            a = BASE[r] + (24'($urandom) & 24'h00_0FFE) + 24'(!wd);
            mux = MUX_T[r];
            nar = NAR_T[r];
            pol = 1'($urandom);
            fcw[3][5] = pol;
            acc(a, 1'b1, wd, d);
            check(cs_seen, 5'(~(5'h01 << r)));
            em[a] = d[7:0];
            if (wd)
                em[a + 1] = d[15:8];
            acc(a, 1'b0, wd, 16'h0000);
            check(q, wd ? {mb(a + 1), mb(a)} : {8'h00, mb(a)});
        end
        mux = 0;
        nar = 0;
        // Address and segment line limits on a default-set write
        for (int k = 0; k < 4; k++) begin
            i_addr_width <= 5'(aw_t[k]);
            i_seg_lines <= 3'(sl_t[k]);
            acc(24'h35_6789, 1'b1, 1'b0, 16'h00A5);
            check(a_seen, 24'h35_6789 & 24'(((1 << aw_t[k]) - 1) &
                  ((1 << (16 + sl_t[k])) - 1)));
        end
        // Window three widened over one and two must still win
        asel[2] = 16'h1004;
        acc(24'h10_0010, 1'b1, 1'b0, 16'h0077);
        check(cs_seen, 5'h17);
        acc(24'h20_7000, 1'b1, 1'b1, 16'h1234);
        check(cs_seen, 5'h1E);
        acc(24'h20_0010, 1'b0, 1'b1, 16'h0000);
        check(q, 16'h3c2c);
        acc(24'h20_8002, 1'b1, 1'b1, 16'h5555);
        check(ipb_seen, 24'h20_8002);
        check(ipw, 24'h03_5555);
        check(cs_seen, 5'h1F);
        i_single_chip <= 1'b1;
        acc(24'h05_0000, 1'b0, 1'b1, 16'h0000);
        check(e, 1'b1);
        check(cs_seen, 5'h1F);
        check(rk, 1'b1);
        results();
    end
endmodule // tb_top
